// ==== verilog/fsam_cfg.svh ====
// Constants for the flash status byte and array map block
`ifndef FSAM_CFG_SVH
`define FSAM_CFG_SVH
// Status byte bit positions
`define FSAM_BIT_BUSY      0
`define FSAM_BIT_WARM      1
`define FSAM_BIT_PROT_LO   2
`define FSAM_BIT_PROT_HI   5
`define FSAM_BIT_QUAD      6
`define FSAM_BIT_LOCK      7
`define FSAM_STATUS_RESET  8'h00
`define FSAM_NV_RESET      6'h00
// Opcodes that need the write-arm latch
`define FSAM_OP_PAGE_PROG  8'h02
`define FSAM_OP_QPROG_A    8'h32
`define FSAM_OP_QPROG_B    8'h38
`define FSAM_OP_SECT_A     8'hD7
`define FSAM_OP_SECT_B     8'h20
`define FSAM_OP_BLK32      8'h52
`define FSAM_OP_BLK64      8'hD8
`define FSAM_OP_CHIP_A     8'hC7
`define FSAM_OP_CHIP_B     8'h60
`define FSAM_OP_STAT_WR    8'h01
`define FSAM_OP_FUNC_WR    8'h42
`define FSAM_OP_INFO_PROG  8'h62
// Opcodes that steer the latch and read the status byte
`define FSAM_OP_ARM        8'h06
`define FSAM_OP_DISARM     8'h04
`define FSAM_OP_STAT_RD    8'h05
// Address fields
`define FSAM_SECT_LSB      12
`define FSAM_BLK32_LSB     15
`define FSAM_BLK64_LSB     16
`endif

// ==== verilog/fsam_pkg.sv ====
// Types shared by the flash status byte and array map block
package fsam_pkg;
  typedef enum logic [1:0] {
    FSAM_ST_IDLE   = 2'b00,
    FSAM_ST_BUSY   = 2'b01,
    FSAM_ST_FINISH = 2'b11
  } fsam_state_e;

  typedef enum logic [2:0] {
    FSAM_K_NONE    = 3'h0,
    FSAM_K_PROG    = 3'h1,
    FSAM_K_SECTOR  = 3'h2,
    FSAM_K_BLK32   = 3'h3,
    FSAM_K_BLK64   = 3'h4,
    FSAM_K_CHIP    = 3'h5,
    FSAM_K_STATUS  = 3'h6,
    FSAM_K_REGPROG = 3'h7
  } fsam_kind_e;
endpackage

// ==== verilog/fsam_ctl_if.sv ====
// Control carrier between the command sequencer and the status bits
`timescale 1ns/100ps
`default_nettype none
interface fsam_ctl_if;
  logic       arm;
  logic       disarm;
  logic       nv_write;
  logic [5:0] nv_data;
  logic       cyc_start;
  logic       cyc_end;
  logic [7:0] status;

  modport ctrl (output arm, output disarm, output nv_write, output nv_data,
                output cyc_start, output cyc_end, input status);
  modport regs (input arm, input disarm, input nv_write, input nv_data,
                input cyc_start, input cyc_end, output status);
endinterface
`default_nettype wire

// ==== verilog/fsam_status_bits.sv ====
// Status byte storage: busy flag, write-arm latch and retained bits
`include "fsam_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module fsam_status_bits
  import fsam_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Control carrier
  fsam_ctl_if.regs  ctl
);
  logic       busy_flag;
  logic       write_arm_latch;
  logic [5:0] nv_bits;

  // Busy runs from cycle start to cycle end
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      busy_flag <= 1'b0;
    else if (ctl.cyc_start)
      busy_flag <= 1'b1;
    else if (ctl.cyc_end)
      busy_flag <= 1'b0;
  end

  // Latch moves only on arm, disarm or cycle end; status write never touches it
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      write_arm_latch <= 1'b0;
    else if (ctl.arm)
      write_arm_latch <= 1'b1;
    else if (ctl.disarm || ctl.cyc_end)
      write_arm_latch <= 1'b0;
  end

  // Retained bits; there is no real cell here, so reset stands in for factory state
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      nv_bits <= `FSAM_NV_RESET;
    else if (ctl.nv_write)
      nv_bits <= ctl.nv_data;
  end

  // Byte layout: lock, quad, four protect bits, latch, busy
  assign ctl.status = {nv_bits, write_arm_latch, busy_flag};
endmodule
`default_nettype wire

// ==== verilog/fsam_addr_map.sv ====
// Sector and block index decode of a byte address
`include "fsam_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module fsam_addr_map
  import fsam_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Address capture
  input  wire logic        load,
  input  wire logic [23:0] addr,
  // Indices
  output logic      [11:0] sector_index,
  output logic      [8:0]  block32_index,
  output logic      [7:0]  block64_index
);
  // One shift serves every granularity
  function automatic logic [11:0] field_of(input logic [23:0] a, input int lsb);
    logic [23:0] s;
    s = a >> lsb;
    return s[11:0];
  endfunction

  // Full-width fields; a call result cannot be part-selected, so narrow them here
  logic [11:0] blk32_field;
  logic [11:0] blk64_field;

  assign blk32_field = field_of(addr, `FSAM_BLK32_LSB);
  assign blk64_field = field_of(addr, `FSAM_BLK64_LSB);

  // Indices held for the whole internal cycle
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sector_index  <= 12'h000;
      block32_index <= 9'h000;
      block64_index <= 8'h00;
    end
    else if (load)
    begin
      sector_index  <= field_of(addr, `FSAM_SECT_LSB);
      block32_index <= blk32_field[8:0];
      block64_index <= blk64_field[7:0];
    end
  end
endmodule
`default_nettype wire

// ==== verilog/fsam_top.sv ====
// Command gate, write-arm sequencing and pin roles of the flash status byte
`include "fsam_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module fsam_top
  import fsam_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Decoded command from the serial front end
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_opcode,
  input  wire logic [23:0] cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  // Variant strap: 1 for the larger arrays with 64 KB blocks
  input  wire logic        large_array,
  // Protect and hold pin levels
  input  wire logic        wp_n_in,
  input  wire logic        hold_n_in,
  // Array engine handshake
  input  wire logic        op_done,
  output logic             op_start,
  output fsam_kind_e       op_kind,
  // Address map
  output logic [11:0]      sector_index,
  output logic [8:0]       block32_index,
  output logic [7:0]       block64_index,
  // Status byte and read answer
  output logic [7:0]       status_byte,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  // Pin roles and refusals
  output logic             quad_active,
  output logic             hold_active_n,
  output logic             cmd_ignored
);
  fsam_ctl_if ctl ();

  fsam_state_e state;
  fsam_state_e next_state;
  fsam_kind_e  kind_q;
  logic [5:0]  nv_pending;
  logic        addr_load;

  // Live views of the stored byte
  logic       busy_now;
  logic       arm_now;
  logic [3:0] prot_now;
  logic       quad_now;
  logic       lock_now;

  assign busy_now = ctl.status[`FSAM_BIT_BUSY];
  assign arm_now  = ctl.status[`FSAM_BIT_WARM];
  assign prot_now = ctl.status[`FSAM_BIT_PROT_HI:`FSAM_BIT_PROT_LO];
  assign quad_now = ctl.status[`FSAM_BIT_QUAD];
  assign lock_now = ctl.status[`FSAM_BIT_LOCK];

  fsam_status_bits u_bits (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ctl      (ctl)
  );

  fsam_addr_map u_map (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .load          (addr_load),
    .addr          (cmd_addr),
    .sector_index  (sector_index),
    .block32_index (block32_index),
    .block64_index (block64_index)
  );

  // Opcodes that need the latch and start an internal cycle
  function automatic fsam_kind_e kind_of(input logic [7:0] op, input logic big);
    fsam_kind_e k;
    k = FSAM_K_NONE;
    case (op)
      `FSAM_OP_PAGE_PROG,
      `FSAM_OP_QPROG_A,
      `FSAM_OP_QPROG_B:   k = FSAM_K_PROG;
      `FSAM_OP_SECT_A,
      `FSAM_OP_SECT_B:    k = FSAM_K_SECTOR;
      `FSAM_OP_BLK32:     k = FSAM_K_BLK32;
      `FSAM_OP_BLK64:     k = big ? FSAM_K_BLK64 : FSAM_K_BLK32;
      `FSAM_OP_CHIP_A,
      `FSAM_OP_CHIP_B:    k = FSAM_K_CHIP;
      `FSAM_OP_STAT_WR:   k = FSAM_K_STATUS;
      `FSAM_OP_FUNC_WR,
      `FSAM_OP_INFO_PROG: k = FSAM_K_REGPROG;
      default:            k = FSAM_K_NONE;
    endcase
    return k;
  endfunction

  // Classification of the command in hand
  fsam_kind_e in_kind;
  logic       is_write_cmd;
  logic       is_arm;
  logic       is_disarm;
  logic       is_read;
  logic       lock_hw;
  logic       write_ok;

  assign in_kind      = kind_of(cmd_opcode, large_array);
  assign is_write_cmd = (in_kind != FSAM_K_NONE);
  assign is_arm       = cmd_valid && (cmd_opcode == `FSAM_OP_ARM);
  assign is_disarm    = cmd_valid && (cmd_opcode == `FSAM_OP_DISARM);
  assign is_read      = cmd_valid && (cmd_opcode == `FSAM_OP_STAT_RD);

  // With quad on the protect pin is a data line, so hardware locking is lost
  assign lock_hw = lock_now && !wp_n_in && !quad_now;

  // Acceptance: idle, not busy, latch armed, and no protection veto
  always_comb
  begin
    write_ok = cmd_valid && is_write_cmd && (state == FSAM_ST_IDLE)
               && !busy_now
               && arm_now;
    if (in_kind == FSAM_K_STATUS && lock_hw)
      write_ok = 1'b0;
    if (in_kind == FSAM_K_CHIP && prot_now != 4'h0)
      write_ok = 1'b0;
  end

  // Cycle sequencer: idle, busy until the engine reports done, one finish cycle
  always_comb
  begin
    next_state = state;
    case (state)
      FSAM_ST_IDLE:   if (write_ok) next_state = FSAM_ST_BUSY;
      FSAM_ST_BUSY:   if (op_done)  next_state = FSAM_ST_FINISH;
      FSAM_ST_FINISH: next_state = FSAM_ST_IDLE;
      default:        next_state = FSAM_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      state <= FSAM_ST_IDLE;
    else
      state <= next_state;
  end

  // Kind and pending retained bits held for the length of the cycle
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      kind_q     <= FSAM_K_NONE;
      nv_pending <= `FSAM_NV_RESET;
    end
    else if (write_ok)
    begin
      kind_q     <= in_kind;
      nv_pending <= cmd_wdata[`FSAM_BIT_LOCK:`FSAM_BIT_PROT_LO];
    end
  end

  // Strobes into the status bits; arm while busy is dropped, as writes are
  always_comb
  begin
    ctl.arm       = is_arm && !busy_now && (state == FSAM_ST_IDLE);
    ctl.disarm    = is_disarm && (state == FSAM_ST_IDLE);
    ctl.cyc_start = write_ok;
    ctl.cyc_end   = (state == FSAM_ST_FINISH);
    ctl.nv_write  = (state == FSAM_ST_FINISH) && (kind_q == FSAM_K_STATUS);
    ctl.nv_data   = nv_pending;
  end

  assign addr_load = write_ok;

  // Engine start pulse with its kind; status writes run through the engine too
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      op_start <= 1'b0;
      op_kind  <= FSAM_K_NONE;
    end
    else
    begin
      op_start <= write_ok;
      if (write_ok)
        op_kind <= in_kind;
    end
  end

  // Status read answers even while busy so the host can poll completion
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      rd_valid <= 1'b0;
      rd_data  <= `FSAM_STATUS_RESET;
    end
    else
    begin
      rd_valid <= is_read;
      if (is_read)
        rd_data <= ctl.status;
    end
  end

  // Registered copy of the byte; lags the stored bits by one cycle
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      status_byte <= `FSAM_STATUS_RESET;
    else
      status_byte <= ctl.status;
  end

  // Pin roles follow the quad enable bit
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      quad_active   <= 1'b0;
      hold_active_n <= 1'b1;
    end
    else
    begin
      quad_active   <= quad_now;
      hold_active_n <= quad_now ? 1'b1 : hold_n_in;
    end
  end

  // Refusal pulse for any write-class command that was not taken
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      cmd_ignored <= 1'b0;
    else
      cmd_ignored <= (cmd_valid && is_write_cmd && !write_ok)
                     || (is_arm && !ctl.arm) || (is_disarm && !ctl.disarm);
  end
endmodule
`default_nettype wire

// ==== verification/fsam_monitor.sv ====
// Port-level assertions for the flash status byte block
`timescale 1ns/100ps
`default_nettype none
module fsam_monitor
  import fsam_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // Watched ports
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic       wp_n_in,
  input wire logic       op_start,
  input wire logic [7:0] status_byte,
  input wire logic       rd_valid,
  input wire logic       quad_active,
  input wire logic       hold_active_n,
  input wire logic       cmd_ignored
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Recent arm and disarm commands; two or three edges cover the status lag
  logic [2:0] arm_d;
  logic [2:0] dis_d;
  always_ff @(posedge core_clk)
  begin
    arm_d <= {arm_d[1:0], cmd_valid && cmd_opcode == 8'h06};
    dis_d <= {dis_d[1:0], cmd_valid && cmd_opcode == 8'h04};
  end

  // Start seen while armed and idle, then busy shows
  sequence s_armed_then_busy;
    status_byte[1:0] == 2'b10 ##1 status_byte[0];
  endsequence
  // Busy and latch drop in the same cycle
  sequence s_cycle_end;
    $fell(status_byte[0]) ##0 !status_byte[1];
  endsequence

  a_start_when_armed: assert property (op_start |-> s_armed_then_busy)
    else $error("start without armed idle status");
  a_busy_cause: assert property ($rose(status_byte[0]) |-> $past(op_start))
    else $error("busy rose without a start");
  a_end_together: assert property ($fell(status_byte[0]) |-> s_cycle_end)
    else $error("busy cleared with latch still set");
  a_retained_at_end: assert property (!$stable(status_byte[7:2]) |-> $fell(status_byte[0]))
    else $error("retained bits changed outside cycle end");
  a_arm_cause: assert property ($rose(status_byte[1]) |-> |arm_d[2:1])
    else $error("latch set without arm command");
  a_disarm_cause: assert property ($fell(status_byte[1]) && !$fell(status_byte[0]) |-> |dis_d[2:1])
    else $error("latch cleared without disarm");
  a_read_answer: assert property (cmd_valid && cmd_opcode == 8'h05 |-> ##[1:2] rd_valid)
    else $error("status read not answered");
  a_erase_veto: assert property (cmd_valid && (cmd_opcode == 8'hc7 || cmd_opcode == 8'h60)
    && status_byte[5:2] != 4'h0 |-> ##[1:2] cmd_ignored)
    else $error("chip erase not refused while protected");
  a_lock_veto: assert property (cmd_valid && cmd_opcode == 8'h01 && status_byte[7] && !wp_n_in
    && !status_byte[6] |-> ##[1:2] cmd_ignored)
    else $error("status write not refused while locked");
  a_refuse_quiet: assert property (cmd_ignored |-> !op_start)
    else $error("refused command started a cycle");
  a_quad_hold: assert property (quad_active |-> hold_active_n)
    else $error("hold active while quad enabled");
endmodule

bind fsam_top fsam_monitor u_mon (.core_clk(core_clk), .nrst(nrst), .cmd_valid(cmd_valid),
  .cmd_opcode(cmd_opcode), .wp_n_in(wp_n_in), .op_start(op_start), .status_byte(status_byte),
  .rd_valid(rd_valid), .quad_active(quad_active), .hold_active_n(hold_active_n), .cmd_ignored(cmd_ignored));
`default_nettype wire

// ==== verification/fsam_engine_model.sv ====
// Array engine stand-in that answers each start after a set delay
`timescale 1ns/100ps
`default_nettype none
module fsam_engine_model
(
  // Clock and handshake
  input  wire logic       core_clk,
  input  wire logic       op_start,
  output logic            op_done,
  // Answer delay in cycles, at least one
  input  wire logic [7:0] delay
);
  logic [7:0] cnt;
  logic       run;

  // One done pulse per start; a long delay keeps the block busy for read-back
  always_ff @(posedge core_clk)
  begin
    op_done <= 1'b0;
    if (op_start)
    begin
      run <= 1'b1;
      cnt <= delay;
    end
    else if (run)
    begin
      cnt <= cnt - 8'h01;
      if (cnt <= 8'h01)
      begin
        run     <= 1'b0;
        op_done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/fsam_top_tb.sv ====
// Self-checking bench for the flash status byte block
`timescale 1ns/100ps
`default_nettype none
module fsam_top_tb;
  import fsam_pkg::*;
  logic        core_clk, nrst, cmd_valid, large_array, wp_n_in, hold_n_in;
  logic        op_done, op_start, rd_valid, quad_active, hold_active_n, cmd_ignored;
  logic        saw_start, saw_ign;
  logic [7:0]  cmd_opcode, cmd_wdata, status_byte, rd_data, dly, got_rd;
  logic [23:0] cmd_addr;
  logic [11:0] sector_index;
  logic [8:0]  block32_index;
  logic [7:0]  block64_index;
  fsam_kind_e  op_kind;
  int          num_errors, checked;
  // Write-class opcodes and their kinds; the last runs on the small variant
  logic [7:0]  ops [12] = '{8'h02, 8'h32, 8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60, 8'h42, 8'h62, 8'hd8};
  fsam_kind_e  kinds [12] = '{FSAM_K_PROG, FSAM_K_PROG, FSAM_K_PROG, FSAM_K_SECTOR, FSAM_K_SECTOR,
    FSAM_K_BLK32, FSAM_K_BLK64, FSAM_K_CHIP, FSAM_K_CHIP, FSAM_K_REGPROG, FSAM_K_REGPROG, FSAM_K_BLK32};

  fsam_top dut (.core_clk(core_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .large_array(large_array), .wp_n_in(wp_n_in),
    .hold_n_in(hold_n_in), .op_done(op_done), .op_start(op_start), .op_kind(op_kind),
    .sector_index(sector_index), .block32_index(block32_index), .block64_index(block64_index),
    .status_byte(status_byte), .rd_valid(rd_valid), .rd_data(rd_data), .quad_active(quad_active),
    .hold_active_n(hold_active_n), .cmd_ignored(cmd_ignored));
  fsam_engine_model u_eng (.core_clk(core_clk), .op_start(op_start), .op_done(op_done), .delay(dly));

  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk_v(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_f(input logic got, input logic exp);
    chk_v({23'h0, got}, {23'h0, exp});
  endtask

  // One command pulse, then three cycles of watching the answers
  task automatic send(input logic [7:0] op, input logic [7:0] d);
    @(posedge core_clk);
    cmd_valid  <= 1'b1;
    cmd_opcode <= op;
    cmd_wdata  <= d;
    @(posedge core_clk);
    cmd_valid  <= 1'b0;
    saw_start = 1'b0;
    saw_ign   = 1'b0;
    repeat (3)
    begin
      #1;
      saw_start = saw_start | op_start;
      saw_ign   = saw_ign | cmd_ignored;
      if (rd_valid) got_rd = rd_data;
      @(posedge core_clk);
    end
  endtask

  task automatic rd(input logic [7:0] exp);
    got_rd = 8'hxx;
    send(8'h05, 8'h00);
    chk_v(got_rd, exp);
  endtask

  // Bounded wait for the busy flag to drop
  task automatic idle;
    int n;
    n = 0;
    while (status_byte[0] !== 1'b0 && n < 300)
    begin
      @(posedge core_clk);
      n++;
    end
    chk_f(status_byte[0], 1'b0);
    repeat (2) @(posedge core_clk);
  endtask

  // Arm, issue, expect start or refusal, then read back the status byte
  task automatic wr(input logic [7:0] op, input logic [7:0] d, input logic ok, input logic [7:0] exp);
    send(8'h06, 8'h00);
    send(op, d);
    chk_f(saw_start, ok);
    chk_f(saw_ign, !ok);
    idle();
    rd(exp);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run of a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    results();
  end

  initial
  begin
    {nrst, cmd_valid, large_array, wp_n_in, hold_n_in} = 5'b00111;
    {cmd_opcode, cmd_wdata, cmd_addr} = '0;
    {num_errors, checked} = '0;
    dly = 8'h01;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    rd(8'h00);
    chk_f(hold_active_n, 1'b1);
    send(8'h02, 8'h00);
    chk_f(saw_ign, 1'b1);
    chk_f(saw_start, 1'b0);
    send(8'h06, 8'h00);
    rd(8'h02);
    send(8'h04, 8'h00);
    rd(8'h00);
    $display("test arm and disarm done");
    // Slow engine: read busy, refuse arm and a back-to-back write
    dly      <= 8'h28;
    cmd_addr <= 24'h07_9abc;
    send(8'h06, 8'h00);
    send(8'h02, 8'h00);
    chk_f(saw_start, 1'b1);
    chk_v(sector_index, cmd_addr[23:12]);
    chk_v(block32_index, cmd_addr[23:15]);
    chk_v(block64_index, cmd_addr[23:16]);
    rd(8'h03);
    send(8'h06, 8'h00);
    chk_f(saw_ign, 1'b1);
    send(8'h02, 8'h00);
    chk_f(saw_ign, 1'b1);
    idle();
    rd(8'h00);
    dly <= 8'h01;
    $display("test busy cycle done");
    for (int i = 0; i < 12; i++)
    begin
      large_array <= (i != 11);
      wr(ops[i], 8'h00, 1'b1, 8'h00);
      chk_v(op_kind, kinds[i]);
    end
    $display("test opcode table done");
    wr(8'h01, 8'hff, 1'b1, 8'hfc);
    chk_f(quad_active, 1'b1);
    hold_n_in <= 1'b0;
    wr(8'hc7, 8'h00, 1'b0, 8'hfe);
    chk_f(hold_active_n, 1'b1);
    send(8'h04, 8'h00);
    wr(8'h01, 8'h80, 1'b1, 8'h80);
    chk_f(hold_active_n, 1'b0);
    wp_n_in <= 1'b0;
    wr(8'h01, 8'h00, 1'b0, 8'h82);
    wp_n_in <= 1'b1;
    wr(8'h01, 8'h00, 1'b1, 8'h00);
    $display("test status write done");
    results();
  end
endmodule
`default_nettype wire
